// ==== hw/flash_host.sv ====
/*
 * Host-side controller that drives a multi-die flash device over its
 * multiplexed 8-bit bus: command, address, write and read cycles,
 * ready/busy wait. Assumes the pins are wired straight to the device
 * and a pull-up on the ready/busy lines.
 */
`timescale 1ns/1ps

module flash_host
   import flash_host_pkg::*;
#(
   parameter int unsigned STROBE_CYCLES = STROBE_CYC
) (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // User request
   input  wire logic        req_valid,
   input  wire host_req_t   req,
   input  wire logic        wp_enable,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   // Flash control pins
   output flash_ctl_t       ctl,
   // Shared bus, three signals
   input  wire logic [7:0]  bus_in,
   output logic [7:0]       bus_out,
   output logic             bus_oe,
   // Ready/busy pins, open-drain from the device
   input  wire logic        ready_busy_n,
   input  wire logic        second_ready_busy_n
);

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_LOW   = 3'b011,
      ST_HIGH  = 3'b010,
      ST_WAIT  = 3'b110
   } state_t;

   state_t             state_r;
   state_t             state_nxt;
   host_req_t          cur_r;
   flash_ctl_t         ctl_r;
   logic [7:0]         bus_out_r;
   logic               bus_oe_r;
   logic [CNT_W-1:0]   cnt_r;
   logic [2:0]         acyc_r;
   logic               rsp_valid_r;
   logic               req_ready_r;
   logic [7:0]         rsp_data_r;
   logic [SYNC_STAGES-1:0] rb0_sync_r;
   logic [SYNC_STAGES-1:0] rb1_sync_r;
   logic               rb0_r;
   logic               rb1_r;

   // ----------------------------------------------------------------
   // Ready/busy synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rb0_sync_r <= '1;
         rb1_sync_r <= '1;
         rb0_r      <= 1'b1;
         rb1_r      <= 1'b1;
      end else begin
         rb0_sync_r <= {rb0_sync_r[SYNC_STAGES-2:0], ready_busy_n};
         rb1_sync_r <= {rb1_sync_r[SYNC_STAGES-2:0], second_ready_busy_n};
         if (rb0_sync_r[1] == rb0_sync_r[2]) rb0_r <= rb0_sync_r[2];
         if (rb1_sync_r[1] == rb1_sync_r[2]) rb1_r <= rb1_sync_r[2];
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic cnt_done   = (cnt_r == CNT_W'(STROBE_CYCLES - 1));
   wire logic is_read    = (cur_r.kind == OP_RDATA);
   wire logic is_addr    = (cur_r.kind == OP_ADDR);
   wire logic sel_ready  = cur_r.sel_upper ? rb1_r : rb0_r;
   wire logic last_acyc  = (acyc_r == 3'(ADDR_CYCLES - 1));
   wire logic take       = (state_r == ST_IDLE) && req_valid;
   // Address byte for the current cycle, first byte lowest
   wire logic [7:0] addr_byte = cur_r.addr[acyc_r*8 +: 8];
   // Byte for a write pulse
   wire logic [7:0] wr_byte = is_addr ? addr_byte : cur_r.data;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Active-low select, low only for the half in use
   function automatic logic sel_n(input logic act, input logic upper,
                                  input logic want);
      return !(act && (upper == want));
   endfunction

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (req_valid) begin
            state_nxt = (req.kind == OP_WAIT) ? ST_WAIT : ST_SETUP;
         end
         ST_SETUP: if (cnt_done) state_nxt = ST_LOW;
         ST_LOW:   if (cnt_done) state_nxt = ST_HIGH;
         ST_HIGH:  if (cnt_done) begin
            state_nxt = (is_addr && !last_acyc) ? ST_LOW : ST_IDLE;
         end
         ST_WAIT:  if (cnt_done && sel_ready) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencing registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         cur_r   <= '0;
         cnt_r   <= '0;
         acyc_r  <= '0;
      end else begin
         state_r <= state_nxt;
         if (take) cur_r <= req;
         if (state_nxt != state_r) cnt_r <= '0;
         else if (!cnt_done) cnt_r <= cnt_r + 1'b1;
         if (take) acyc_r <= '0;
         else if (state_r == ST_HIGH && cnt_done && is_addr && !last_acyc)
            acyc_r <= acyc_r + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   wire logic active  = (state_nxt == ST_SETUP) || (state_nxt == ST_LOW)
                      || (state_nxt == ST_HIGH);
   wire host_req_t nreq = take ? req : cur_r;
   wire logic n_read  = (nreq.kind == OP_RDATA);
   wire logic strobe_lo = (state_nxt == ST_LOW);
   // Each select falls only for the half that the request names
   wire logic lo_sel_n  = sel_n(active, nreq.sel_upper, 1'b0);
   wire logic hi_sel_n  = sel_n(active, nreq.sel_upper, 1'b1);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctl_r.cmd_latch            <= 1'b0;
         ctl_r.addr_latch           <= 1'b0;
         ctl_r.chip_sel_n           <= 1'b1;
         ctl_r.second_chip_select_n <= 1'b1;
         ctl_r.write_strobe_n       <= 1'b1;
         ctl_r.read_strobe_n        <= 1'b1;
         ctl_r.write_protect_n      <= 1'b0;
         req_ready_r                <= 1'b1;
      end else begin
         ctl_r.write_protect_n      <= wp_enable ? 1'b0 : 1'b1;
         ctl_r.chip_sel_n           <= lo_sel_n;
         ctl_r.second_chip_select_n <= hi_sel_n;
         // Latches only high inside their own cycle, never together
         ctl_r.cmd_latch  <= active && (nreq.kind == OP_CMD);
         ctl_r.addr_latch <= active && (nreq.kind == OP_ADDR);
         ctl_r.write_strobe_n <= !(strobe_lo && !n_read);
         ctl_r.read_strobe_n  <= !(strobe_lo && n_read);
         // Ready in the cycle the state returns to idle
         req_ready_r <= (state_nxt == ST_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Bus and read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_out_r   <= BUS_RST;
         bus_oe_r    <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= BUS_RST;
      end else begin
         // Host drives the bus only during command, address and write data cycles
         bus_oe_r  <= active && !n_read;
         bus_out_r <= (state_r == ST_LOW || state_r == ST_HIGH)
                      ? wr_byte : (take ? req.data : wr_byte);
         rsp_valid_r <= 1'b0;
         // Sample read byte just before the strobe rises
         if (state_r == ST_LOW && cnt_done && is_read) begin
            rsp_valid_r <= 1'b1;
            rsp_data_r  <= bus_in;
         end
      end
   end

   assign req_ready = req_ready_r;
   assign ctl       = ctl_r;
   assign bus_out   = bus_out_r;
   assign bus_oe    = bus_oe_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp_data  = rsp_data_r;

endmodule // flash_host

// ==== hw/flash_host_pkg.sv ====
/*
 * Shared constants and carrier types for the flash bus host controller.
 * Assumes a single 20 MHz system clock domain.
 */
package flash_host_pkg;
   // -----------------------------------------------------------------
   // Clock and strobe timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 20;
   localparam int unsigned STROBE_NS      = 100;
   localparam int unsigned STROBE_CYC     =
      (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W          = 4;
   localparam int unsigned SYNC_STAGES    = 3;

   // -----------------------------------------------------------------
   // Array geometry
   // -----------------------------------------------------------------
   localparam int unsigned PLANES_PER_DIE  = 2;
   localparam int unsigned BLOCKS_PER_PLANE = 2048;
   localparam int unsigned PAGES_PER_BLOCK = 64;
   localparam int unsigned PAGE_BYTES      = 2112;
   localparam int unsigned PAGE_DATA_BYTES = 2048;
   localparam int unsigned PAGE_SPARE_BYTES = 64;
   localparam int unsigned ADDR_CYCLES     = 5;
   localparam int unsigned ADDR_W          = 40;

   // -----------------------------------------------------------------
   // Request kinds and reset values
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_CMD   = 3'h0,
      OP_ADDR  = 3'h1,
      OP_WDATA = 3'h2,
      OP_RDATA = 3'h3,
      OP_WAIT  = 3'h4
   } op_kind_t;

   localparam logic [7:0] BUS_RST = 8'h00;

   typedef struct packed {
      op_kind_t    kind;
      logic        sel_upper;
      logic [7:0]  data;
      logic [ADDR_W-1:0] addr;
   } host_req_t;

   typedef struct packed {
      logic       cmd_latch;
      logic       addr_latch;
      logic       chip_sel_n;
      logic       second_chip_select_n;
      logic       write_strobe_n;
      logic       read_strobe_n;
      logic       write_protect_n;
   } flash_ctl_t;
endpackage

// ==== testbench/flash_host_asserts.sv ====
/* Checker for the flash host pin sequencing.
   Bound to the ports of flash_host; default strobe phase of 2 cycles. */
`timescale 1ns/1ps
module flash_host_asserts
   import flash_host_pkg::*;
(
   // System
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // Watched outputs
   input wire logic       req_ready,
   input wire flash_ctl_t ctl,
   input wire logic       bus_oe
);
   logic [3:0] n_r;
   // Write strobe rises seen during one address phase
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b) n_r <= 4'h0;
      else if (!ctl.addr_latch) n_r <= 4'h0;
      else if ($rose(ctl.write_strobe_n)) n_r <= n_r + 4'h1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   latch_excl_a: assert property (!(ctl.cmd_latch && ctl.addr_latch))
      else $error("both latch strobes high");
   idle_quiet_a: assert property (req_ready |->
      !ctl.cmd_latch && !ctl.addr_latch) else $error("latch high in idle");
   latch_sel_a: assert property ((ctl.cmd_latch || ctl.addr_latch) |->
      (ctl.chip_sel_n ^ ctl.second_chip_select_n)) else $error("bad select");
   strobe_excl_a: assert property (ctl.write_strobe_n || ctl.read_strobe_n)
      else $error("both strobes low");
   rd_release_a: assert property (!ctl.read_strobe_n |-> !bus_oe)
      else $error("host drives bus in read");
   wr_drive_a: assert property (!ctl.write_strobe_n |-> bus_oe)
      else $error("bus floats in write");
   addr_five_a: assert property ($fell(ctl.addr_latch) |-> n_r == 4'h5)
      else $error("address phase not five bytes");
   we_width_a: assert property ($fell(ctl.write_strobe_n) |->
      !ctl.write_strobe_n [*2] ##1 ctl.write_strobe_n)
      else $error("write strobe width wrong");
endmodule // flash_host_asserts

// ==== testbench/flash_dev_model.sv ====
/* Behavioural flash die with a 16-byte page and status byte.
   Edge-driven by the host strobes; bus resolved by the bench. */
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter int BUSY_NS = 2000
) (
   // Pins from the host
   input  wire flash_ctl_t ctl,
   input  wire logic       ce_n,
   input  wire logic [7:0] din,
   // Read data and ready
   output logic [7:0]      dout,
   output logic            oe,
   output logic            rb_n
);
   logic [7:0] cmd_r = 8'hff;
   logic [7:0] pg [16];
   int         wp_i  = 0;
   int         rp_i  = 0;
   int         ac_i  = 0;
   initial rb_n = 1'b1;
   // Count address bytes from the start of each address phase
   always @(posedge ctl.addr_latch) ac_i = 0;
   assign oe = !ce_n && !ctl.read_strobe_n;
   always @(posedge ctl.write_strobe_n) if (!ce_n) begin
      if (ctl.cmd_latch && (rb_n || din == 8'h70)) begin
         cmd_r = din;
         if (din == 8'h10 && ctl.write_protect_n) begin
            rb_n = 1'b0;
            rb_n <= #(BUSY_NS) 1'b1;
         end
      end else if (ctl.addr_latch) begin
         // First address byte is the column
         if (ac_i == 0) begin
            wp_i = din;
            rp_i = din;
         end
         ac_i++;
      end else if (rb_n && wp_i < PAGE_BYTES) begin
         pg[wp_i % 16] = din;
         wp_i++;
      end
   end
   always @(negedge ctl.read_strobe_n) if (!ce_n) begin
      dout = cmd_r == 8'h70 ? {ctl.write_protect_n, rb_n, 6'h00}
                            : pg[rp_i % 16];
      rp_i++;
   end
endmodule // flash_dev_model

// ==== testbench/flash_host_tb.sv ====
/* Self-checking bench for flash_host driving two model dies.
   Assumes the package defaults and a 50 ns clock. */
`timescale 1ns/1ps
module flash_host_tb
   import flash_host_pkg::*;
;
   logic       clk_sys = 0, rst_b = 0, req_valid = 0, wp_enable = 0;
   host_req_t  req = '0;
   logic       req_ready, rsp_valid, bus_oe, oe0, oe1, rb0, rb1;
   logic [7:0] rsp_data, bus_out, d0, d1, bus_in, v;
   flash_ctl_t ctl;
   int         failures = 0, tests_run = 0;
   assign bus_in = bus_oe ? bus_out : oe0 ? d0 : oe1 ? d1 : ~bus_out;
   flash_host dut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
      .req(req), .wp_enable(wp_enable), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ctl(ctl),
      .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
      .ready_busy_n(rb0), .second_ready_busy_n(rb1));
   flash_dev_model lo (.ctl(ctl), .ce_n(ctl.chip_sel_n), .din(bus_in),
      .dout(d0), .oe(oe0), .rb_n(rb0));
   flash_dev_model hi (.ctl(ctl), .ce_n(ctl.second_chip_select_n),
      .din(bus_in), .dout(d1), .oe(oe1), .rb_n(rb1));
   initial forever #25 clk_sys = ~clk_sys;
   task automatic results;
      if (failures == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(string nm, logic [7:0] s, logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic send(op_kind_t k, logic u, logic [7:0] d);
      @(posedge clk_sys);
      #1;
      req = '{k, u, d, {32'h0, d}};
      req_valid = 1'b1;
      for (int n = 0; req_ready !== 1'b1; n++) begin
         if (n == 1000) begin failures++; results(); end
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
   endtask
   task automatic rd(logic u, output logic [7:0] b);
      send(OP_RDATA, u, 8'h00);
      for (int n = 0; rsp_valid !== 1'b1; n++) begin
         if (n == 100) begin failures++; results(); end
         @(posedge clk_sys);
         #1;
      end
      b = rsp_data;
   endtask
   task automatic t_prog(logic u, logic [7:0] base);
      send(OP_CMD, u, 8'h80);
      send(OP_ADDR, u, 8'h00);
      for (int i = 0; i < 4; i++) send(OP_WDATA, u, base + 8'(i));
      send(OP_CMD, u, 8'h10);
      send(OP_CMD, u, 8'h70);
      rd(u, v);
      check("busy status", v, {~wp_enable, wp_enable, 6'h00});
      send(OP_WAIT, u, 8'h00);
      rd(u, v);
      check("done status", v, {~wp_enable, 7'h40});
   endtask
   task automatic t_read(logic u, logic [7:0] base);
      send(OP_CMD, u, 8'h00);
      send(OP_ADDR, u, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(u, v);
         check("read byte", v, base + 8'(i));
      end
      send(OP_ADDR, u, 8'h02);
      rd(u, v);
      check("column byte", v, base + 8'h02);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      t_prog(1'b0, 8'h10);
      t_prog(1'b1, 8'h50);
      t_read(1'b0, 8'h10);
      t_read(1'b1, 8'h50);
      wp_enable = 1'b1;
      t_prog(1'b0, 8'h90);
      results();
   end
endmodule // flash_host_tb
bind flash_host flash_host_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .req_ready(req_ready), .ctl(ctl), .bus_oe(bus_oe));
